// *** inc/pnpg_defines.svh ***
// Offsets, field positions, reset values and limits of the next-page, gigabit and MMD window registers.
// Assumes a 32-bit Wishbone slave: each register is one word at byte address 4 * index.
`ifndef PNPG_DEFINES_SVH
`define PNPG_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define PNPG_IDX_AN_EXPANSION   6'h06
`define PNPG_IDX_NP_TX          6'h07
`define PNPG_IDX_LP_NP_RX       6'h08
`define PNPG_IDX_GIG_CTRL       6'h09
`define PNPG_IDX_GIG_STAT       6'h0a
`define PNPG_IDX_MMD_CTRL       6'h0d
`define PNPG_IDX_MMD_WINDOW     6'h0e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PNPG_NP_TOGGLE_BIT      11
`define PNPG_NP_WR_MASK         16'hb7ff
`define PNPG_GC_TMODE_MSB       15
`define PNPG_GC_TMODE_LSB       13
`define PNPG_GC_MS_MANUAL_BIT   12
`define PNPG_GC_MS_VALUE_BIT    11
`define PNPG_GC_PORT_BIT        10
`define PNPG_GC_FULL_DPX_BIT    9
`define PNPG_GC_HALF_DPX_BIT    8
`define PNPG_MMD_FN_MSB         15
`define PNPG_MMD_FN_LSB         14
`define PNPG_MMD_DEV_MSB        4
`define PNPG_EXP_NP_ABLE_BIT    2
`define PNPG_EXP_PAGE_RX_BIT    1

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PNPG_NP_TX_RST          16'h2001
`define PNPG_GIG_CTRL_RST       16'h0700
`define PNPG_MMD_CTRL_RST       16'h0000
`define PNPG_TMODE_MAX          3'h4
`define PNPG_IDLE_CNT_MAX       8'hff

`endif

// *** inc/pnpg_pkg.sv ***
// Types shared by the next-page / gigabit / MMD register block and its surroundings.
// Assumes the PHY core delivers its events as one-cycle strobes on clk_sys.
`default_nettype none
package pnpg_pkg;

	typedef enum logic [1:0] {
		PNPG_FN_ADDR     = 2'h0,
		PNPG_FN_DATA     = 2'h1,
		PNPG_FN_DATA_INC = 2'h2,
		PNPG_FN_DATA_WINC = 2'h3
	} pnpg_mmd_fn_t;

	typedef struct packed {
		logic        page_rx_stb;
		logic [15:0] page_rx_word;
		logic        page_tx_stb;
		logic        page_tx_toggle;
		logic        ms_fault_stb;
		logic        ms_res_master;
		logic        local_rx_ok;
		logic        remote_rx_ok;
		logic        lp_gig_full_duplex;
		logic        lp_gig_half_duplex;
		logic        idle_err_stb;
	} pnpg_phy_stat_t;

	typedef struct packed {
		logic [15:0] np_tx_word;
		logic [2:0]  tx_test_mode;
		logic        ms_force_master;
		logic        ms_force_slave;
		logic        port_multi;
		logic        adv_full_duplex;
		logic        adv_half_duplex;
	} pnpg_phy_ctl_t;

	typedef struct packed {
		logic        wr_stb;
		logic        rd_stb;
		logic [4:0]  dev;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pnpg_mmd_req_t;

	typedef struct packed {
		logic        ack;
		logic [15:0] rdat;
		logic [15:0] np_tx;
		logic        np_toggle;
		logic [15:0] lp_np;
		logic [15:0] gctl;
		logic        ms_fault;
		logic        ms_res;
		logic        page_rx;
		logic [7:0]  idle_cnt;
		logic [15:0] mmd_ctl;
		logic [15:0] mmd_addr;
		logic        mmd_wr;
		logic [15:0] mmd_wr_addr;
		logic [15:0] mmd_wdata;
	} pnpg_state_t;

endpackage
`default_nettype wire

// *** hw/pnpg_regs.sv ***
// Next-page, gigabit control/status and MMD access window registers behind a classic Wishbone slave.
// Assumes all PHY status inputs and the MMD read data are synchronous to clk_sys.
`include "pnpg_defines.svh"
`default_nettype none

// Operation
// - Writable next-page transmit register, message default one.
// - Acknowledge-2 bit writable, resets to zero.
// - Toggle reads inverse of last sent toggle.
// - Partner next page captured read-only, resets zero.
// - Partner acknowledge-2 reported as received.
// - Three-bit test mode, reserved codes mean normal.
// - Test modes passed to PHY per gigabit standard.
// - Forced master/slave value needs manual enable.
// - Manual enable: value one master, zero slave.
// - Advertised duplex and port type default one.
// - Master/slave fault latches high until read.
// - Resolution bit reports master, default one.
// - Local and remote receiver status bits.
// - Partner gigabit duplex capability bits.
// - Registers 13 and 14 form MMD window.
// - Function field selects address or data mode.
// - Code 11 increments after writes only.
// - Device select field targets the MMD.
// - Function 00 write loads MMD address.
// - Other functions transfer MMD data.
// - Page received latches until read.
// - Local PHY reports next-page capable.
module pnpg_regs
	import pnpg_pkg::*;
#(
	parameter int ADR_W = 8
) (
	input  wire logic                clk_sys,
	input  wire logic                arst_n,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [ADR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire pnpg_phy_stat_t      phy_stat,
	output pnpg_phy_ctl_t            phy_ctl,
	output pnpg_mmd_req_t            mmd_req,
	input  wire logic [15:0]         mmd_rdata
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	pnpg_state_t  st_ff;
	pnpg_state_t  nxt_st;
	logic         take;
	logic         take_wr;
	logic         take_rd;
	logic [5:0]   idx;
	logic [15:0]  cur_rd;
	logic [15:0]  wr_val;
	pnpg_mmd_fn_t fn;
	logic         mmd_data_rd;

	// Merge byte lanes so a partial write keeps the untouched half of cur_rd, which for the MMD data window is mmd_rdata
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [1:0] sel);
		lane_merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	function automatic logic [2:0] legal_tmode(input logic [2:0] code);
		legal_tmode = (code > `PNPG_TMODE_MAX) ? 3'h0 : code;
	endfunction

	// A request is taken once; ack blocks it for the following cycle
	assign take    = wb_cyc_i && wb_stb_i && !st_ff.ack;
	assign take_wr = take && wb_we_i;
	assign take_rd = take && !wb_we_i;
	assign idx     = 6'(wb_adr_i[ADR_W-1:2]);
	assign fn      = pnpg_mmd_fn_t'(st_ff.mmd_ctl[`PNPG_MMD_FN_MSB:`PNPG_MMD_FN_LSB]);
	assign mmd_data_rd = take_rd && idx == `PNPG_IDX_MMD_WINDOW && fn != PNPG_FN_ADDR;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		cur_rd = 16'h0000;
		unique case (idx)
			`PNPG_IDX_AN_EXPANSION: begin
				cur_rd[`PNPG_EXP_NP_ABLE_BIT] = 1'b1;
				cur_rd[`PNPG_EXP_PAGE_RX_BIT] = st_ff.page_rx;
			end
			`PNPG_IDX_NP_TX: begin
				cur_rd = st_ff.np_tx;
				cur_rd[`PNPG_NP_TOGGLE_BIT] = st_ff.np_toggle;
			end
			`PNPG_IDX_LP_NP_RX: cur_rd = st_ff.lp_np;
			`PNPG_IDX_GIG_CTRL: cur_rd = st_ff.gctl;
			`PNPG_IDX_GIG_STAT: begin
				cur_rd = {st_ff.ms_fault, st_ff.ms_res, phy_stat.local_rx_ok, phy_stat.remote_rx_ok,
					phy_stat.lp_gig_full_duplex, phy_stat.lp_gig_half_duplex, 2'h0, st_ff.idle_cnt};
			end
			`PNPG_IDX_MMD_CTRL: cur_rd = st_ff.mmd_ctl;
			`PNPG_IDX_MMD_WINDOW: cur_rd = (fn == PNPG_FN_ADDR) ? st_ff.mmd_addr : mmd_rdata;
			default: cur_rd = 16'h0000;
		endcase
	end

	assign wr_val = lane_merge(cur_rd, wb_dat_i[15:0], wb_sel_i[1:0]);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.ack    = take;
		nxt_st.mmd_wr = 1'b0;
		nxt_st.ms_res = phy_stat.ms_res_master;
		if (take_rd) begin
			nxt_st.rdat = cur_rd;
		end
		// Clears on read come first so that a same-cycle event still sets
		if (take_rd && idx == `PNPG_IDX_GIG_STAT) begin
			nxt_st.ms_fault = 1'b0;
			nxt_st.idle_cnt = 8'h00;
		end
		if (take_rd && idx == `PNPG_IDX_AN_EXPANSION) begin
			nxt_st.page_rx = 1'b0;
		end
		if (take_wr) begin
			unique case (idx)
				`PNPG_IDX_NP_TX: nxt_st.np_tx = wr_val & `PNPG_NP_WR_MASK;
				`PNPG_IDX_GIG_CTRL: nxt_st.gctl = wr_val;
				`PNPG_IDX_MMD_CTRL: nxt_st.mmd_ctl = wr_val;
				`PNPG_IDX_MMD_WINDOW: begin
					if (fn == PNPG_FN_ADDR) begin
						nxt_st.mmd_addr = wr_val;
					end else begin
						nxt_st.mmd_wr      = 1'b1;
						nxt_st.mmd_wr_addr = st_ff.mmd_addr;
						nxt_st.mmd_wdata   = wr_val;
						if (fn != PNPG_FN_DATA) begin
							nxt_st.mmd_addr = st_ff.mmd_addr + 16'h0001;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// read increment only for code 10
		if (mmd_data_rd && fn == PNPG_FN_DATA_INC) begin
			nxt_st.mmd_addr = st_ff.mmd_addr + 16'h0001;
		end
		if (phy_stat.page_tx_stb) begin
			nxt_st.np_toggle = !phy_stat.page_tx_toggle;
		end
		if (phy_stat.page_rx_stb) begin
			nxt_st.lp_np   = phy_stat.page_rx_word;
			nxt_st.page_rx = 1'b1;
		end
		if (phy_stat.ms_fault_stb) begin
			nxt_st.ms_fault = 1'b1;
		end
		if (phy_stat.idle_err_stb && nxt_st.idle_cnt != `PNPG_IDLE_CNT_MAX) begin
			nxt_st.idle_cnt = nxt_st.idle_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_ff             <= '0;
			st_ff.np_tx       <= `PNPG_NP_TX_RST;
			st_ff.gctl        <= `PNPG_GIG_CTRL_RST;
			st_ff.mmd_ctl     <= `PNPG_MMD_CTRL_RST;
			st_ff.ms_res      <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = {16'h0000, st_ff.rdat};

	always_comb begin
		phy_ctl = '0;
		phy_ctl.np_tx_word = st_ff.np_tx;
		phy_ctl.np_tx_word[`PNPG_NP_TOGGLE_BIT] = st_ff.np_toggle;
		phy_ctl.tx_test_mode = legal_tmode(st_ff.gctl[`PNPG_GC_TMODE_MSB:`PNPG_GC_TMODE_LSB]);
		phy_ctl.ms_force_master = st_ff.gctl[`PNPG_GC_MS_MANUAL_BIT] && st_ff.gctl[`PNPG_GC_MS_VALUE_BIT];
		phy_ctl.ms_force_slave  = st_ff.gctl[`PNPG_GC_MS_MANUAL_BIT] && !st_ff.gctl[`PNPG_GC_MS_VALUE_BIT];
		phy_ctl.port_multi      = st_ff.gctl[`PNPG_GC_PORT_BIT];
		phy_ctl.adv_full_duplex = st_ff.gctl[`PNPG_GC_FULL_DPX_BIT];
		phy_ctl.adv_half_duplex = st_ff.gctl[`PNPG_GC_HALF_DPX_BIT];
	end

	// Read strobe is combinational so mmd_rdata is sampled in the same cycle
	always_comb begin
		mmd_req        = '0;
		mmd_req.dev    = st_ff.mmd_ctl[`PNPG_MMD_DEV_MSB:0];
		mmd_req.rd_stb = mmd_data_rd;
		mmd_req.wr_stb = st_ff.mmd_wr;
		mmd_req.addr   = st_ff.mmd_wr ? st_ff.mmd_wr_addr : st_ff.mmd_addr;
		mmd_req.wdata  = st_ff.mmd_wdata;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	logic gstat_rd;
	assign gstat_rd = take_rd && idx == `PNPG_IDX_GIG_STAT;
	logic exp_rd;
	logic np_wr;
	logic ctl_wr;
	logic mmd_ctl_wr;
	logic win_wr;
	assign exp_rd     = take_rd && idx == `PNPG_IDX_AN_EXPANSION;
	assign np_wr      = take_wr && idx == `PNPG_IDX_NP_TX;
	assign ctl_wr     = take_wr && idx == `PNPG_IDX_GIG_CTRL;
	assign mmd_ctl_wr = take_wr && idx == `PNPG_IDX_MMD_CTRL;
	assign win_wr     = take_wr && idx == `PNPG_IDX_MMD_WINDOW;

	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	AST_TOGGLE: assert property (phy_stat.page_tx_stb |=>
		phy_ctl.np_tx_word[11] != $past(phy_stat.page_tx_toggle)) else $error("toggle not inverted");
	AST_LP_CAPTURE: assert property (phy_stat.page_rx_stb |=>
		st_ff.lp_np == $past(phy_stat.page_rx_word) && st_ff.page_rx) else $error("partner page lost");
	AST_FAULT_HOLD: assert property (st_ff.ms_fault && !gstat_rd |=> st_ff.ms_fault)
		else $error("fault dropped without read");
	AST_TMODE_LEGAL: assert property (phy_ctl.tx_test_mode <= 3'h4) else $error("reserved test mode");
	AST_FORCE: assert property (take_wr && idx == `PNPG_IDX_GIG_CTRL && wb_sel_i[1] &&
		wb_dat_i[12:11] == 2'h3 |=> phy_ctl.ms_force_master && !phy_ctl.ms_force_slave)
		else $error("manual master not forced");
	AST_NO_FORCE: assert property (!st_ff.gctl[12] |-> !phy_ctl.ms_force_master &&
		!phy_ctl.ms_force_slave) else $error("forced without manual enable");
	AST_IDLE_SAT: assert property (st_ff.idle_cnt == 8'hff && !gstat_rd |=> st_ff.idle_cnt == 8'hff)
		else $error("idle count wrapped");
	AST_IDLE_CLR: assert property (gstat_rd && !phy_stat.idle_err_stb |=> st_ff.idle_cnt == 8'h00
		&& wb_dat_o[7:0] == $past(st_ff.idle_cnt)) else $error("idle count not cleared on read");
	AST_ADDR_LOAD: assert property (take_wr && idx == `PNPG_IDX_MMD_WINDOW && fn == PNPG_FN_ADDR &&
		wb_sel_i[1:0] == 2'h3 |=> mmd_req.addr == $past(wb_dat_i[15:0])) else $error("MMD address not loaded");
	AST_RD_INC: assert property (mmd_req.rd_stb && fn == PNPG_FN_DATA_INC |=>
		st_ff.mmd_addr == $past(st_ff.mmd_addr) + 16'h0001) else $error("no read increment");
	AST_RD_NOINC: assert property (mmd_req.rd_stb && fn == PNPG_FN_DATA_WINC |=>
		$stable(st_ff.mmd_addr)) else $error("read incremented in write-only mode");
	AST_WR_STROBE: assert property (take_wr && idx == `PNPG_IDX_MMD_WINDOW && fn != PNPG_FN_ADDR |=>
		mmd_req.wr_stb ##1 !mmd_req.wr_stb) else $error("MMD write strobe wrong");

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// Every taken request is answered one cycle later, and nothing else raises ack
	AST_ACK_TAKE: assert property (take |=> wb_ack_o)
		else $error("request not acknowledged");
	AST_ACK_IDLE: assert property (!take |=> !wb_ack_o)
		else $error("ack without a request");

	// ----------------------------------------
	// Next page registers
	// ----------------------------------------
	AST_ACK2_WRITE: assert property (np_wr && wb_sel_i[1] |=>
		phy_ctl.np_tx_word[12] == $past(wb_dat_i[12]) && !phy_ctl.np_tx_word[14])
		else $error("acknowledge-2 not written");
	AST_TOGGLE_HOLD: assert property (!phy_stat.page_tx_stb |=> $stable(phy_ctl.np_tx_word[11]))
		else $error("toggle moved without a sent page");
	AST_LP_HOLD: assert property (!phy_stat.page_rx_stb |=> $stable(st_ff.lp_np))
		else $error("partner page changed without a received page");
	// Read returns the flag as it was before the clear
	AST_PAGE_HOLD: assert property (st_ff.page_rx && !exp_rd |=> st_ff.page_rx)
		else $error("page received dropped without read");
	AST_PAGE_CLR: assert property (exp_rd && !phy_stat.page_rx_stb |=> !st_ff.page_rx &&
		wb_dat_o[1] == $past(st_ff.page_rx)) else $error("page received not cleared on read");
	AST_NP_ABLE: assert property (exp_rd |=> wb_dat_o[2])
		else $error("next-page ability not reported");

	// ----------------------------------------
	// Gigabit control and status
	// ----------------------------------------
	AST_TMODE_PASS: assert property (ctl_wr && wb_sel_i[1] && wb_dat_i[15:13] <= 3'h4 |=>
		phy_ctl.tx_test_mode == $past(wb_dat_i[15:13])) else $error("test mode not passed on");
	AST_TMODE_RSVD: assert property (ctl_wr && wb_sel_i[1] && wb_dat_i[15:13] > 3'h4 |=>
		phy_ctl.tx_test_mode == 3'h0) else $error("reserved test mode not held at normal");
	AST_FORCE_SLAVE: assert property (ctl_wr && wb_sel_i[1] && wb_dat_i[12:11] == 2'h2 |=>
		phy_ctl.ms_force_slave && !phy_ctl.ms_force_master) else $error("manual slave not forced");
	AST_ADV: assert property (ctl_wr && wb_sel_i[1] |=> phy_ctl.port_multi == $past(wb_dat_i[10]) &&
		phy_ctl.adv_full_duplex == $past(wb_dat_i[9]) && phy_ctl.adv_half_duplex == $past(wb_dat_i[8]))
		else $error("port type or advertised duplex not written");
	AST_FAULT_SET: assert property (phy_stat.ms_fault_stb |=> st_ff.ms_fault)
		else $error("fault event lost");
	// Resolution is registered, so a read shows the level of two edges back
	AST_RES_READ: assert property (gstat_rd |=> wb_dat_o[14] == $past(phy_stat.ms_res_master, 2))
		else $error("resolution not reported");
	AST_IDLE_INC: assert property (phy_stat.idle_err_stb && !gstat_rd && st_ff.idle_cnt != 8'hff |=>
		st_ff.idle_cnt == $past(st_ff.idle_cnt) + 8'h01) else $error("idle error not counted");
	AST_IDLE_EVT_WINS: assert property (gstat_rd && phy_stat.idle_err_stb |=> st_ff.idle_cnt == 8'h01)
		else $error("idle error lost under read");

	// ----------------------------------------
	// MMD window
	// ----------------------------------------
	// Device select has to reach the far side unchanged before any window access
	AST_DEV_SELECT: assert property (mmd_ctl_wr && wb_sel_i[0] |=> mmd_req.dev == $past(wb_dat_i[4:0]))
		else $error("device select not applied");
	AST_WR_DATA: assert property (win_wr && fn != PNPG_FN_ADDR && wb_sel_i[1:0] == 2'h3 |=>
		mmd_req.addr == $past(st_ff.mmd_addr) && mmd_req.wdata == $past(wb_dat_i[15:0]))
		else $error("MMD write data or address wrong");
	AST_WR_INC: assert property (win_wr && (fn == PNPG_FN_DATA_INC || fn == PNPG_FN_DATA_WINC) |=>
		st_ff.mmd_addr == $past(st_ff.mmd_addr) + 16'h0001) else $error("no write increment");
	AST_DATA_NOINC: assert property ((win_wr || mmd_req.rd_stb) && fn == PNPG_FN_DATA |=>
		$stable(st_ff.mmd_addr)) else $error("address moved without post-increment");

	COV_MMD_WINC: cover property (mmd_req.wr_stb && fn == PNPG_FN_DATA_WINC);
	COV_FAULT_READ: cover property (st_ff.ms_fault ##1 gstat_rd);
	COV_PAGE_RX: cover property (phy_stat.page_rx_stb ##[1:20] take_rd && idx == `PNPG_IDX_LP_NP_RX);
	COV_READ_INC: cover property (mmd_req.rd_stb && fn == PNPG_FN_DATA_INC);
	COV_IDLE_EVT_CLR: cover property (gstat_rd && phy_stat.idle_err_stb);

endmodule // pnpg_regs
`default_nettype wire

// *** tb/pnpg_mmd_model.sv ***
// Far-side model of the EEE MMD register space reached through the access window.
// Assumes one window request at a time from the register block, synchronous to clk_sys.
`default_nettype none
module pnpg_mmd_model
	import pnpg_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire pnpg_mmd_req_t mmd_req,
	output logic      [15:0]   mmd_rdata,
	output logic      [4:0]    last_dev
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [15:0] mem [16];
	logic [15:0] junk;

	initial junk = 16'h5a5a;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always @(posedge clk_sys) begin
		junk <= ~junk;
		if (mmd_req.wr_stb) begin
			mem[mmd_req.addr[3:0]] <= mmd_req.wdata;
			last_dev <= mmd_req.dev;
		end
	end

	// Outside a read the data moves every cycle, so a stale value can never pass for an answer
	assign mmd_rdata = mmd_req.rd_stb ? mem[mmd_req.addr[3:0]] : junk;
endmodule // pnpg_mmd_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the next-page, gigabit and MMD window register block.
// Assumes the MMD model answers window reads in the cycle of the request.
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top
	import pnpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic           clk_sys;
	logic           arst_n;
	logic           cyc;
	logic           stb;
	logic           we;
	logic [7:0]     adr;
	logic [31:0]    wdat;
	logic [3:0]     sel;
	logic [31:0]    wb_dat_o;
	logic           wb_ack_o;
	pnpg_phy_stat_t st;
	pnpg_phy_ctl_t  ctl;
	pnpg_mmd_req_t  mreq;
	logic [15:0]    mrd;
	logic [4:0]     mdev;
	logic [15:0]    rv;
	int             failures;
	int             checks_done;

	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	pnpg_regs #(.ADR_W(8)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .phy_stat(st), .phy_ctl(ctl), .mmd_req(mreq), .mmd_rdata(mrd));

	pnpg_mmd_model far (.clk_sys(clk_sys), .mmd_req(mreq), .mmd_rdata(mrd), .last_dev(mdev));

	// ----------------------------------------
	// Bus and event helpers
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [15:0] d, input logic [3:0] s = 4'h3);
		int n;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'b00};
		wdat <= {16'h0000, d};
		sel  <= s;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rv = wb_dat_o[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) failures++;
		@(posedge clk_sys);
	endtask

	task automatic rc(input logic [5:0] idx, input logic [15:0] e);
		xfer(1'b0, idx, 16'h0000);
		`CHK($sformatf("reg_%h", idx), e, rv)
	endtask

	task automatic tx_page(input logic t);
		st.page_tx_toggle <= t;
		st.page_tx_stb <= 1'b1;
		@(posedge clk_sys);
		st.page_tx_stb <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rc(6'h06, 16'h0004);
		rc(6'h07, 16'h2001);
		rc(6'h08, 16'h0000);
		rc(6'h09, 16'h0700);
		rc(6'h0a, 16'h4000);
		rc(6'h0d, 16'h0000);
		xfer(1'b1, 6'h08, 16'hffff);
		rc(6'h08, 16'h0000);
		xfer(1'b1, 6'h3f, 16'hffff);
		rc(6'h3f, 16'h0000);
	endtask

	task automatic t_np;
		xfer(1'b1, 6'h07, 16'hffff);
		rc(6'h07, 16'hb7ff);
		tx_page(1'b0);
		rc(6'h07, 16'hbfff);
		`CHK("np_tx_word", 16'hbfff, ctl.np_tx_word)
		tx_page(1'b1);
		rc(6'h07, 16'hb7ff);
		xfer(1'b1, 6'h07, 16'h0800);
		rc(6'h07, 16'h0000);
	endtask

	task automatic t_lp;
		st.page_rx_word <= 16'hdabc;
		st.page_rx_stb <= 1'b1;
		@(posedge clk_sys);
		st.page_rx_stb <= 1'b0;
		rc(6'h08, 16'hdabc);
		rc(6'h06, 16'h0006);
		rc(6'h06, 16'h0004);
	endtask

	task automatic t_gig;
		for (int m = 0; m < 8; m++) begin
			xfer(1'b1, 6'h09, {m[2:0], 13'h0000});
			`CHK("tx_test_mode", (m < 5) ? m[2:0] : 3'h0, ctl.tx_test_mode)
		end
		rc(6'h09, 16'he000);
		xfer(1'b1, 6'h09, 16'h1800);
		`CHK("ms_force", 2'b10, {ctl.ms_force_master, ctl.ms_force_slave})
		xfer(1'b1, 6'h09, 16'h1000);
		`CHK("ms_force", 2'b01, {ctl.ms_force_master, ctl.ms_force_slave})
		xfer(1'b1, 6'h09, 16'h08a5);
		`CHK("ms_force", 2'b00, {ctl.ms_force_master, ctl.ms_force_slave})
		`CHK("adv", 3'b000, {ctl.port_multi, ctl.adv_full_duplex, ctl.adv_half_duplex})
		rc(6'h09, 16'h08a5);
		xfer(1'b1, 6'h09, 16'hf7ff, 4'h1);
		rc(6'h09, 16'h08ff);
		xfer(1'b1, 6'h09, 16'h0700, 4'h2);
		`CHK("adv", 3'b111, {ctl.port_multi, ctl.adv_full_duplex, ctl.adv_half_duplex})
		rc(6'h09, 16'h07ff);
	endtask

	task automatic t_stat;
		st.local_rx_ok <= 1'b1;
		st.remote_rx_ok <= 1'b1;
		st.lp_gig_full_duplex <= 1'b1;
		st.lp_gig_half_duplex <= 1'b1;
		st.ms_fault_stb <= 1'b1;
		st.idle_err_stb <= 1'b1;
		repeat (3) @(posedge clk_sys);
		st.ms_fault_stb <= 1'b0;
		st.idle_err_stb <= 1'b0;
		rc(6'h0a, 16'hfc03);
		st.ms_res_master <= 1'b0;
		@(posedge clk_sys);
		rc(6'h0a, 16'h3c00);
		st.idle_err_stb <= 1'b1;
		repeat (300) @(posedge clk_sys);
		st.idle_err_stb <= 1'b0;
		rc(6'h0a, 16'h3cff);
		rc(6'h0a, 16'h3c00);
		// Events during the clearing read must survive it
		st.ms_fault_stb <= 1'b1;
		st.idle_err_stb <= 1'b1;
		rc(6'h0a, 16'h3c00);
		st.ms_fault_stb <= 1'b0;
		st.idle_err_stb <= 1'b0;
		rc(6'h0a, 16'hbc03);
	endtask

	task automatic t_mmd;
		xfer(1'b1, 6'h0d, 16'h0005);
		xfer(1'b1, 6'h0e, 16'h0003);
		xfer(1'b1, 6'h0d, 16'h8005);
		xfer(1'b1, 6'h0e, 16'h1111);
		xfer(1'b1, 6'h0e, 16'h2222);
		`CHK("mmd_dev", 5'h05, mdev)
		xfer(1'b1, 6'h0d, 16'h0005);
		rc(6'h0e, 16'h0005);
		xfer(1'b1, 6'h0e, 16'h0003);
		xfer(1'b1, 6'h0d, 16'h4005);
		rc(6'h0e, 16'h1111);
		rc(6'h0e, 16'h1111);
		xfer(1'b1, 6'h0d, 16'h8005);
		rc(6'h0e, 16'h1111);
		rc(6'h0e, 16'h2222);
		xfer(1'b1, 6'h0d, 16'hc005);
		xfer(1'b0, 6'h0e, 16'h0000);
		xfer(1'b1, 6'h0e, 16'h3333);
		`CHK("mmd_slot5", 16'h3333, far.mem[5])
		xfer(1'b1, 6'h0d, 16'h0005);
		rc(6'h0e, 16'h0006);
	endtask

	// Reset in mid-run returns every writable field to its default
	task automatic t_rst_mid;
		xfer(1'b1, 6'h09, 16'h98ff);
		`CHK("tx_test_mode", 3'h4, ctl.tx_test_mode)
		`CHK("ms_force", 2'b10, {ctl.ms_force_master, ctl.ms_force_slave})
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		`CHK("ms_force", 2'b00, {ctl.ms_force_master, ctl.ms_force_slave})
		`CHK("adv", 3'b111, {ctl.port_multi, ctl.adv_full_duplex, ctl.adv_half_duplex})
		rc(6'h09, 16'h0700);
		rc(6'h07, 16'h2001);
		rc(6'h0e, 16'h0000);
	endtask

	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		failures = 0;
		checks_done = 0;
		arst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		sel = 4'h0;
		st = '0;
		st.ms_res_master = 1'b1;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_np;
		t_lp;
		t_gig;
		t_stat;
		t_mmd;
		t_rst_mid;
		results;
	end

	// The whole run needs well under a thousand cycles; five thousand means a hang
	initial begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		results;
	end
endmodule // tb_top
`default_nettype wire
